// >>> design/aut_params.svh
// Constants for the API/CLI serial link with time capture
`ifndef AUT_PARAMS_SVH
`define AUT_PARAMS_SVH
// ==========================================================
// Clocks and rates
`define AUT_CLK_HZ 20000000
`define AUT_OSC_HZ 7372800
`define AUT_API_BAUD 115200
`define AUT_CLI_BAUD 9600
`define AUT_DIV(clk, baud) (((clk) + (baud) / 2) / (baud))
// ==========================================================
// Gaps between packets, in microseconds, then in cycles; strobe low width in cycles
`define AUT_TX_GAP_US 100
`define AUT_RX_GAP_US 100
`define AUT_US_CYC(us, clk) ((us) * ((clk) / 1000000))
`define AUT_CAP_LOW_CYC 8'h04
// ==========================================================
// Framing and packet codes
`define AUT_HDLC_FLAG 8'h7e
`define AUT_HDLC_ESC 8'h7d
`define AUT_HDLC_XOR 8'h20
`define AUT_CMD_READ_TIME 8'h17
`define AUT_PKT_TIME 8'h18
`define AUT_PKT_END 3'h7
`define AUT_UART_BITS 4'ha
`endif

// >>> design/aut_pkg.sv
// Types for the API/CLI serial link with time capture
package aut_pkg;
  typedef enum logic [1:0] {DEV_IDLE, DEV_REQ, DEV_SEND, DEV_GAP}
    aut_dev_st_t;
  typedef enum logic [2:0] {H_IDLE, H_WAIT, H_OPEN, H_DATA, H_CLOSE,
    H_GAP} aut_host_st_t;
  typedef struct packed {
    logic        idle;
    logic [9:0]  sh;
    logic [3:0]  nbit;
    logic [15:0] div;
    logic        txd;
  } aut_utx_t;
  typedef struct packed {
    logic        busy;
    logic [7:0]  sh;
    logic [3:0]  nbit;
    logic [15:0] div;
    logic [7:0]  data;
    logic        valid;
  } aut_urx_t;
  typedef struct packed {
    aut_dev_st_t     st;
    logic [1:0]      tcr_s;
    logic [1:0]      cts_s;
    logic [1:0]      rts_s;
    logic [1:0]      rx_s;
    logic [1:0]      cli_s;
    logic            tcr_q;
    logic [31:0]     time_cnt;
    logic [31:0]     cap_stamp;
    logic [31:0]     stamp;
    logic            cap_pend;
    logic            api_pend;
    logic [15:0]     rx_hist;
    logic [2:0]      idx;
    logic            esc;
    logic [15:0]     gap;
    logic [1:0][7:0] fmem;
    logic            wp;
    logic            rp;
    logic [1:0]      cnt;
    logic            tx_rts_n;
    logic            rx_cts_n;
    logic            awake;
  } aut_dev_t;
  typedef struct packed {
    aut_host_st_t st;
    logic [1:0]   tx_s;
    logic [1:0]   trts_s;
    logic [1:0]   rcts_s;
    logic [15:0]  gap;
    logic         esc;
    logic         resc;
    logic         got;
    logic         ack;
    logic         rx_rts_n;
    logic         tx_cts_n;
    logic         tcr_n;
    logic [7:0]   cap_cnt;
    logic [7:0]   rx_data;
    logic         rx_valid;
    logic         rx_end;
  } aut_host_t;
endpackage : aut_pkg

// >>> design/aut_link_if.sv
// Pins between the device end and the companion end
`timescale 1ns/1ns
interface aut_link_if;
  logic api_rx;                 // Companion to device data
  logic api_tx;                 // Device to companion data
  logic rx_rts_n;               // Companion wants to send
  logic rx_cts_n;               // Device clear for companion
  logic tx_rts_n;               // Device wants to send
  logic tx_cts_n;               // Companion clear for device
  logic time_capture_request_n; // Time strobe
  logic cli_rx;                 // CLI into device
  logic cli_tx;                 // CLI out of device
  modport dev (
    input  api_rx, rx_rts_n, tx_cts_n, time_capture_request_n, cli_rx,
    output api_tx, rx_cts_n, tx_rts_n, cli_tx
  );
  modport host (
    input  api_tx, rx_cts_n, tx_rts_n,
    output api_rx, rx_rts_n, tx_cts_n, time_capture_request_n
  );
endinterface : aut_link_if

// >>> design/aut_device.sv
// Device end: API UART, time packets, CLI UART, wake on activity
`timescale 1ns/1ns
`include "aut_params.svh"

// ==========================================================
// Device end
module aut_device
#(
  parameter int CLK_HZ     = `AUT_CLK_HZ,
  parameter int API_BAUD   = `AUT_API_BAUD,
  parameter int CLI_BAUD   = `AUT_CLI_BAUD,
  parameter int TX_GAP_CYC = `AUT_US_CYC(`AUT_TX_GAP_US, `AUT_CLK_HZ)
)
(
  input  wire logic  ref_clk,      // System clock
  input  wire logic  rst_n,        // Async reset, active low
  aut_link_if.dev    link,         // Pins to the companion
  output logic [7:0] api_rx_data,  // Byte from companion
  output logic       api_rx_valid, // Pulse per API byte
  output logic [7:0] cli_rx_data,  // Byte from CLI
  output logic       cli_rx_valid, // Pulse per CLI byte
  input  wire logic [7:0] cli_tx_data,  // Byte for CLI
  input  wire logic       cli_tx_valid, // CLI byte offered
  output logic       cli_tx_ready, // CLI transmitter idle
  output logic       awake         // Activity seen, not dozing
);
  // rates are derived from the system clock frequency
  localparam int API_DIV = `AUT_DIV(CLK_HZ, API_BAUD);
  localparam int CLI_DIV = `AUT_DIV(CLK_HZ, CLI_BAUD);

  aut_pkg::aut_dev_t s;
  aut_pkg::aut_dev_t next_s;
  logic       push;
  logic       pop;
  logic [7:0] pbyte;
  logic [7:0] b;
  logic       api_valid;
  logic       api_ready;

  function automatic logic [7:0] pkt_byte(input logic [2:0]  idx,
                                          input logic [31:0] t);
    case (idx)
      3'h1:    pkt_byte = `AUT_PKT_TIME;
      3'h2:    pkt_byte = t[31:24];
      3'h3:    pkt_byte = t[23:16];
      3'h4:    pkt_byte = t[15:8];
      3'h5:    pkt_byte = t[7:0];
      default: pkt_byte = `AUT_HDLC_FLAG;
    endcase
  endfunction : pkt_byte

  // the buffer drains only while sending
  assign api_valid = (s.st == aut_pkg::DEV_SEND) && (s.cnt != 2'h0);
  assign pop       = api_valid && api_ready;

  // ==========================================================
  // Next state
  always_comb
  begin
    next_s = s;
    push   = 1'b0;
    pbyte  = 8'h00;
    b      = pkt_byte(s.idx, s.stamp);
    next_s.tcr_s = {s.tcr_s[0], link.time_capture_request_n};
    next_s.cts_s = {s.cts_s[0], link.tx_cts_n};
    next_s.rts_s = {s.rts_s[0], link.rx_rts_n};
    next_s.rx_s  = {s.rx_s[0], link.api_rx};
    next_s.cli_s = {s.cli_s[0], link.cli_rx};
    next_s.tcr_q = s.tcr_s[1];
    // one count per 50 ns clock
    next_s.time_cnt = s.time_cnt + 32'h1;
    case (s.st)
      aut_pkg::DEV_IDLE:
      begin
        if (s.cap_pend || s.api_pend)
        begin
          next_s.st       = aut_pkg::DEV_REQ;
          next_s.tx_rts_n = 1'b0;
          next_s.idx      = 3'h0;
          next_s.esc      = 1'b0;
          if (s.cap_pend)
          begin
            next_s.stamp    = s.cap_stamp;
            next_s.cap_pend = 1'b0;
          end
          else
          begin
            // stamp taken when the packet starts
            next_s.stamp    = s.time_cnt;
            next_s.api_pend = 1'b0;
          end
        end
      end
      aut_pkg::DEV_REQ:
      begin
        if (!s.cts_s[1])
          next_s.st = aut_pkg::DEV_SEND;
      end
      aut_pkg::DEV_SEND:
      begin
        if (s.idx != `AUT_PKT_END)
        begin
          if (s.cnt != 2'h2)
          begin
            // escape flag and escape bytes inside the frame
            push = 1'b1;
            if (!s.esc && (s.idx != 3'h0) && (s.idx != 3'h6) &&
                ((b == `AUT_HDLC_FLAG) || (b == `AUT_HDLC_ESC)))
            begin
              pbyte      = `AUT_HDLC_ESC;
              next_s.esc = 1'b1;
            end
            else
            begin
              pbyte      = s.esc ? (b ^ `AUT_HDLC_XOR) : b;
              next_s.esc = 1'b0;
              next_s.idx = s.idx + 3'h1;
            end
          end
        end
        else if ((s.cnt == 2'h0) && api_ready)
        begin
          // release after the last stop bit
          next_s.tx_rts_n = 1'b1;
          next_s.gap      = 16'(TX_GAP_CYC);
          next_s.st       = aut_pkg::DEV_GAP;
        end
      end
      aut_pkg::DEV_GAP:
      begin
        if (s.gap == 16'h0)
          next_s.st = aut_pkg::DEV_IDLE;
        else
          next_s.gap = s.gap - 16'h1;
      end
      default:
        next_s.st = aut_pkg::DEV_IDLE;
    endcase
    // ==========================================================
    // Triggers, placed after the clears so a new event wins
    // stamp frozen at release of the strobe
    if (s.tcr_s[1] && !s.tcr_q)
    begin
      next_s.cap_stamp = s.time_cnt;
      next_s.cap_pend  = 1'b1;
    end
    // a one-byte read request frame queues a time packet
    if (api_rx_valid)
    begin
      next_s.rx_hist = {s.rx_hist[7:0], api_rx_data};
      if ((api_rx_data == `AUT_HDLC_FLAG) &&
          (s.rx_hist == {`AUT_HDLC_FLAG, `AUT_CMD_READ_TIME}))
        next_s.api_pend = 1'b1;
    end
    // Two-entry buffer: a stalled serialiser stops the builder
    if (push)
    begin
      next_s.fmem[s.wp] = pbyte;
      next_s.wp         = ~s.wp;
    end
    if (pop)
      next_s.rp = ~s.rp;
    case ({push, pop})
      2'b10:   next_s.cnt = s.cnt + 2'h1;
      2'b01:   next_s.cnt = s.cnt - 2'h1;
      default: next_s.cnt = s.cnt;
    endcase
    // always able to take data, so clear mirrors request
    next_s.rx_cts_n = s.rts_s[1];
    // any active input level except the companion clear (tx_cts_n) wakes the block
    next_s.awake = (s.st != aut_pkg::DEV_IDLE) || !s.rx_s[1] ||
                   !s.cli_s[1] || !s.rts_s[1] || !s.tcr_s[1] ||
                   !cli_tx_ready || s.cap_pend || s.api_pend;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s          <= '0;
      s.tcr_s    <= 2'h3;
      s.cts_s    <= 2'h3;
      s.rts_s    <= 2'h3;
      s.rx_s     <= 2'h3;
      s.cli_s    <= 2'h3;
      s.tcr_q    <= 1'b1;
      s.tx_rts_n <= 1'b1;
      s.rx_cts_n <= 1'b1;
    end
    else
      s <= next_s;
  end

  assign link.tx_rts_n = s.tx_rts_n;
  assign link.rx_cts_n = s.rx_cts_n;
  assign awake         = s.awake;

  // ==========================================================
  // Serial engines
  // start, eight bits LSB first, stop
  aut_uart_tx #(.DIV(API_DIV)) u_api_tx (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .data    (s.fmem[s.rp]),
    .valid   (api_valid),
    .ready   (api_ready),
    .txd     (link.api_tx)
  );
  // receiver idle until the line goes low
  aut_uart_rx #(.DIV(API_DIV)) u_api_rx (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .rxd     (s.rx_s[1]),
    .data    (api_rx_data),
    .valid   (api_rx_valid)
  );
  // CLI fixed rate, two wires only
  aut_uart_tx #(.DIV(CLI_DIV)) u_cli_tx (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .data    (cli_tx_data),
    .valid   (cli_tx_valid),
    .ready   (cli_tx_ready),
    .txd     (link.cli_tx)
  );
  aut_uart_rx #(.DIV(CLI_DIV)) u_cli_rx (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .rxd     (s.cli_s[1]),
    .data    (cli_rx_data),
    .valid   (cli_rx_valid)
  );
endmodule : aut_device

// >>> design/aut_host.sv
// Companion end and the serial engines that both ends use
`timescale 1ns/1ns
`include "aut_params.svh"

// ==========================================================
// Serialiser
module aut_uart_tx
#(
  parameter int DIV = 174
)
(
  input  wire logic       ref_clk, // System clock
  input  wire logic       rst_n,   // Async reset, active low
  input  wire logic [7:0] data,    // Byte to send
  input  wire logic       valid,   // Byte offered
  output logic            ready,   // Idle, takes the byte
  output logic            txd      // Serial line
);
  aut_pkg::aut_utx_t s;
  aut_pkg::aut_utx_t next_s;

  always_comb
  begin
    next_s = s;
    if (s.idle)
    begin
      if (valid)
      begin
        next_s.idle = 1'b0;
        next_s.sh   = {1'b1, data, 1'b0};
        next_s.nbit = 4'h0;
        next_s.div  = 16'h0;
      end
    end
    else if (s.div != 16'h0)
      next_s.div = s.div - 16'h1;
    else if (s.nbit == `AUT_UART_BITS)
      next_s.idle = 1'b1;
    else
    begin
      next_s.txd  = s.sh[0];
      next_s.sh   = {1'b1, s.sh[9:1]};
      next_s.nbit = s.nbit + 4'h1;
      next_s.div  = 16'(DIV - 1);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s      <= '0;
      s.idle <= 1'b1;
      s.txd  <= 1'b1;
    end
    else
      s <= next_s;
  end

  assign ready = s.idle;
  assign txd   = s.txd;
endmodule : aut_uart_tx

// ==========================================================
// Deserialiser, line already synchronised
module aut_uart_rx
#(
  parameter int DIV = 174
)
(
  input  wire logic       ref_clk, // System clock
  input  wire logic       rst_n,   // Async reset, active low
  input  wire logic       rxd,     // Synchronised serial line
  output logic [7:0]      data,    // Received byte
  output logic            valid    // One-cycle pulse per byte
);
  aut_pkg::aut_urx_t s;
  aut_pkg::aut_urx_t next_s;

  always_comb
  begin
    next_s = s;
    next_s.valid = 1'b0;
    if (!s.busy)
    begin
      // any low level on the line wakes the counter, not only a falling edge
      if (!rxd)
      begin
        next_s.busy = 1'b1;
        next_s.nbit = 4'h0;
        next_s.div  = 16'(DIV / 2);
      end
    end
    else if (s.div != 16'h0)
      next_s.div = s.div - 16'h1;
    else
    begin
      next_s.div  = 16'(DIV - 1);
      next_s.nbit = s.nbit + 4'h1;
      if (s.nbit == 4'h0)
        next_s.busy = ~rxd;
      else if (s.nbit == 4'h9)
      begin
        // stop bit must be high, else byte dropped
        next_s.busy  = 1'b0;
        next_s.data  = s.sh;
        next_s.valid = rxd;
      end
      else
        next_s.sh = {rxd, s.sh[7:1]};
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      s <= '0;
    else
      s <= next_s;
  end

  assign data  = s.data;
  assign valid = s.valid;
endmodule : aut_uart_rx

// ==========================================================
// Companion end
module aut_host
#(
  parameter int   CLK_HZ       = `AUT_CLK_HZ,
  parameter int   API_BAUD     = `AUT_API_BAUD,
  parameter int   RX_GAP_CYC   = `AUT_US_CYC(`AUT_RX_GAP_US, `AUT_CLK_HZ),
  parameter logic USE_RX_FLOW  = 1'b1,
  parameter logic ALWAYS_READY = 1'b0
)
(
  input  wire logic       ref_clk,   // System clock
  input  wire logic       rst_n,     // Async reset, active low
  aut_link_if.host        link,      // Pins to the device
  input  wire logic [7:0] tx_data,   // Payload byte to send
  input  wire logic       tx_valid,  // Payload byte offered
  input  wire logic       tx_last,   // Byte closes the packet
  output logic            tx_ready,  // Pulse: byte taken
  output logic [7:0]      rx_data,   // Unescaped byte received
  output logic            rx_valid,  // Pulse per byte
  output logic            rx_end,    // Pulse at closing flag
  input  wire logic       accept_en, // Willing to take packets
  input  wire logic       capture    // Pulse: strobe time capture
);
  localparam int API_DIV = `AUT_DIV(CLK_HZ, API_BAUD);

  aut_pkg::aut_host_t s;
  aut_pkg::aut_host_t next_s;
  logic       uv;
  logic [7:0] ud;
  logic       u_ready;
  logic [7:0] r_data;
  logic       r_valid;

  // ==========================================================
  // Next state
  always_comb
  begin
    next_s = s;
    uv     = 1'b0;
    ud     = 8'h00;
    next_s.ack      = 1'b0;
    next_s.rx_valid = 1'b0;
    next_s.rx_end   = 1'b0;
    next_s.tx_s   = {s.tx_s[0], link.api_tx};
    next_s.trts_s = {s.trts_s[0], link.tx_rts_n};
    next_s.rcts_s = {s.rcts_s[0], link.rx_cts_n};
    case (s.st)
      aut_pkg::H_IDLE:
      begin
        if (tx_valid)
        begin
          // without flow control the request stays high
          next_s.rx_rts_n = ~USE_RX_FLOW;
          next_s.st       = aut_pkg::H_WAIT;
        end
      end
      aut_pkg::H_WAIT:
      begin
        if (!USE_RX_FLOW || !s.rcts_s[1])
          next_s.st = aut_pkg::H_OPEN;
      end
      aut_pkg::H_OPEN:
      begin
        uv = 1'b1;
        ud = `AUT_HDLC_FLAG;
        if (u_ready)
          next_s.st = aut_pkg::H_DATA;
      end
      aut_pkg::H_DATA:
      begin
        if (tx_valid && u_ready && !s.ack)
        begin
          uv = 1'b1;
          if (!s.esc && ((tx_data == `AUT_HDLC_FLAG) ||
                         (tx_data == `AUT_HDLC_ESC)))
          begin
            ud         = `AUT_HDLC_ESC;
            next_s.esc = 1'b1;
          end
          else
          begin
            ud         = s.esc ? (tx_data ^ `AUT_HDLC_XOR) : tx_data;
            next_s.esc = 1'b0;
            next_s.ack = 1'b1;
            if (tx_last)
              next_s.st = aut_pkg::H_CLOSE;
          end
        end
      end
      aut_pkg::H_CLOSE:
      begin
        uv = 1'b1;
        ud = `AUT_HDLC_FLAG;
        if (u_ready)
        begin
          next_s.gap = 16'(RX_GAP_CYC);
          next_s.st  = aut_pkg::H_GAP;
        end
      end
      aut_pkg::H_GAP:
      begin
        // gap counted from the end of the last stop bit
        if (u_ready)
        begin
          next_s.rx_rts_n = 1'b1;
          if (s.gap == 16'h0)
            next_s.st = aut_pkg::H_IDLE;
          else
            next_s.gap = s.gap - 16'h1;
        end
      end
      default:
        next_s.st = aut_pkg::H_IDLE;
    endcase
    // ==========================================================
    // Receive path; the data flag set wins over the clear
    if (s.trts_s[1])
      next_s.got = 1'b0;
    if (r_valid)
    begin
      if (r_data == `AUT_HDLC_FLAG)
      begin
        next_s.rx_end = s.got;
        next_s.resc   = 1'b0;
      end
      else if (r_data == `AUT_HDLC_ESC)
        next_s.resc = 1'b1;
      else
      begin
        next_s.rx_data  = s.resc ? (r_data ^ `AUT_HDLC_XOR) : r_data;
        next_s.rx_valid = 1'b1;
        next_s.resc     = 1'b0;
        next_s.got      = 1'b1;
      end
    end
    // clear dropped at first data byte, well before the end
    // or tied low when always ready
    next_s.tx_cts_n = ~ALWAYS_READY &
                      ~(accept_en & ~s.trts_s[1] & ~s.got);
    // strobe low, rising edge marks the capture instant
    if (s.cap_cnt != 8'h0)
    begin
      next_s.cap_cnt = s.cap_cnt - 8'h1;
      next_s.tcr_n   = (s.cap_cnt == 8'h1);
    end
    else if (capture)
    begin
      next_s.cap_cnt = `AUT_CAP_LOW_CYC;
      next_s.tcr_n   = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s          <= '0;
      s.tx_s     <= 2'h3;
      s.trts_s   <= 2'h3;
      s.rcts_s   <= 2'h3;
      s.rx_rts_n <= 1'b1;
      s.tx_cts_n <= 1'b1;
      s.tcr_n    <= 1'b1;
    end
    else
      s <= next_s;
  end

  assign link.rx_rts_n               = s.rx_rts_n;
  assign link.tx_cts_n               = s.tx_cts_n;
  assign link.time_capture_request_n = s.tcr_n;
  assign tx_ready                    = s.ack;
  assign rx_data                     = s.rx_data;
  assign rx_valid                    = s.rx_valid;
  assign rx_end                      = s.rx_end;

  // ==========================================================
  // Serial engines
  aut_uart_tx #(.DIV(API_DIV)) u_tx (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .data    (ud),
    .valid   (uv),
    .ready   (u_ready),
    .txd     (link.api_rx)
  );
  aut_uart_rx #(.DIV(API_DIV)) u_rx (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .rxd     (s.tx_s[1]),
    .data    (r_data),
    .valid   (r_valid)
  );
endmodule : aut_host

// >>> bench/aut_link_props.sv
// Assertions on the pins between device end and companion end
`timescale 1ns/1ns
module aut_link_props
#(
  parameter int GAP = 20
)
(
  input wire logic ref_clk,               // System clock
  input wire logic rst_n,                 // Async reset, active low
  input wire logic api_rx,                // Companion to device
  input wire logic api_tx,                // Device to companion
  input wire logic rx_rts_n,              // Companion wants to send
  input wire logic rx_cts_n,              // Device clear
  input wire logic tx_rts_n,              // Device wants to send
  input wire logic tx_cts_n,              // Companion clear
  input wire logic time_capture_request_n // Time strobe
);
  // ==========================================================
  // Length of the last request-high run
  logic [7:0] hi_cnt;

  // Starts saturated so the first request after reset is legal
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      hi_cnt <= 8'hff;
    else if (!tx_rts_n)
      hi_cnt <= 8'h00;
    else if (hi_cnt != 8'hff)
      hi_cnt <= hi_cnt + 8'h01;
  end

  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  // ==========================================================
  // Properties
  AST_TX_IDLE_NO_REQ: assert property (tx_rts_n |-> api_tx)
    else $error("api_tx active without request");
  AST_START_AFTER_REQ: assert property ($fell(api_tx) |-> !$past(tx_rts_n, 3))
    else $error("start bit too soon after request");
  AST_TX_GAP: assert property ($fell(tx_rts_n) |-> int'(hi_cnt) > GAP)
    else $error("request gap too short");
  AST_REQ_DROP_IDLE: assert property ($rose(tx_rts_n) |-> $past(api_tx))
    else $error("request dropped inside a character");
  AST_CAPTURE_REQ: assert property ($rose(time_capture_request_n)
    |-> ##[1:40] !tx_rts_n)
    else $error("no request after strobe");
  AST_RX_CLEAR: assert property ($fell(rx_rts_n) |-> ##[1:4] !rx_cts_n)
    else $error("receive clear not given");
  AST_RX_CLEAR_DROP: assert property ($rose(rx_rts_n) |-> ##[1:4] rx_cts_n)
    else $error("receive clear not withdrawn");
  AST_START_BIT: assert property ($fell(api_tx) |-> !api_tx [*8])
    else $error("start bit too short");
  AST_STROBE_LOW: assert property ($fell(time_capture_request_n)
    |-> !time_capture_request_n [*4] ##1 time_capture_request_n)
    else $error("strobe width wrong");
  AST_CTS_ON_REQ: assert property ($fell(tx_cts_n) |-> !tx_rts_n)
    else $error("clear given without request");
  AST_HOST_RX_DONE: assert property ($rose(rx_rts_n) |-> $past(api_rx))
    else $error("host request dropped inside a character");
endmodule : aut_link_props

// >>> bench/api_uart_flow_time_capture_bench.sv
// Bench joining the device end to the companion end
`timescale 1ns/1ns
module api_uart_flow_time_capture_bench;
  logic        ref_clk      = 1'b0;
  logic        rst_n        = 1'b0;
  logic [7:0]  tx_data      = 8'h00;
  logic        tx_valid     = 1'b0;
  logic        tx_last      = 1'b0;
  logic        accept_en    = 1'b1;
  logic        capture      = 1'b0;
  logic [7:0]  cli_tx_data  = 8'h00;
  logic        cli_tx_valid = 1'b0;
  logic        cli_tx_ready;
  logic        tx_ready;
  logic        rx_valid;
  logic        rx_end;
  logic [7:0]  rx_data;
  logic [7:0]  cli_rx_data;
  logic [7:0]  api_rx_data;
  logic        cli_rx_valid;
  logic        awake;
  logic [31:0] cyc          = 32'h0;
  logic [7:0]  got[$];
  int          n_errors     = 0;
  int          checks_done  = 0;

  aut_link_if lk ();

  // Command line looped back so one byte tests both directions
  assign lk.cli_rx = lk.cli_tx;

  always #25 ref_clk = ~ref_clk;

  // Mirrors the device time base, cleared by the same reset
  always @(posedge ref_clk)
    cyc <= rst_n ? cyc + 32'h1 : 32'h0;

  aut_device #(.TX_GAP_CYC(20)) i_aut_device (
    .ref_clk(ref_clk), .rst_n(rst_n), .link(lk.dev),
    .api_rx_data(api_rx_data), .api_rx_valid(), .cli_rx_data(cli_rx_data),
    .cli_rx_valid(cli_rx_valid), .cli_tx_data(cli_tx_data),
    .cli_tx_valid(cli_tx_valid), .cli_tx_ready(cli_tx_ready),
    .awake(awake));

  aut_host #(.RX_GAP_CYC(20)) i_aut_host (
    .ref_clk(ref_clk), .rst_n(rst_n), .link(lk.host),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last),
    .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_end(rx_end), .accept_en(accept_en), .capture(capture));

  aut_link_props #(.GAP(20)) i_aut_link_props (
    .ref_clk(ref_clk), .rst_n(rst_n), .api_rx(lk.api_rx),
    .api_tx(lk.api_tx), .rx_rts_n(lk.rx_rts_n), .rx_cts_n(lk.rx_cts_n),
    .tx_rts_n(lk.tx_rts_n), .tx_cts_n(lk.tx_cts_n),
    .time_capture_request_n(lk.time_capture_request_n));

  // ==========================================================
  // Shared helpers
  task automatic check(input string what, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic test_done;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : test_done

  task automatic rx_pkt;
    got.delete();
    // Always steps a cycle first, so a back-to-back call skips the old end
    for (int i = 0; i < 30000; i++)
    begin
      @(negedge ref_clk);
      if (rx_valid)
        got.push_back(rx_data);
      if (rx_end)
        break;
    end
    check("end flag", rx_end, 1'b1);
  endtask : rx_pkt

  task automatic check_pkt(input logic [31:0] lo, input logic [31:0] hi);
    logic [31:0] st;
    check("bytes", 32'(got.size()), 32'h5);
    if (got.size() == 5)
    begin
      st = {got[1], got[2], got[3], got[4]};
      check("type", got[0], 8'h18);
      check("stamp", 32'(st >= lo && st <= hi), 32'h1);
    end
  endtask : check_pkt

  // ==========================================================
  // Scenarios
  // Strobe while the companion refuses; stamp must be the strobe time
  task automatic strobe_scn;
    logic [31:0] t;
    @(posedge ref_clk);
    accept_en <= 1'b0;
    capture   <= 1'b1;
    t = cyc;
    @(posedge ref_clk);
    capture <= 1'b0;
    repeat (60) @(posedge ref_clk);
    @(negedge ref_clk);
    check("request", lk.tx_rts_n, 1'b0);
    check("held line", lk.api_tx, 1'b1);
    check("awake", awake, 1'b1);
    @(posedge ref_clk);
    accept_en <= 1'b1;
    rx_pkt();
    check_pkt(t, t + 32'd16);
    // Stop bit tail and the gap must pass before the device dozes
    repeat (200) @(negedge ref_clk);
    check("dozing", awake, 1'b0);
  endtask : strobe_scn

  // Strobe during a packet: held, then sent after the gap
  task automatic back_scn;
    logic [31:0] t0;
    logic [31:0] t;
    @(posedge ref_clk);
    capture <= 1'b1;
    t0 = cyc;
    @(posedge ref_clk);
    capture <= 1'b0;
    repeat (300) @(posedge ref_clk);
    capture <= 1'b1;
    t = cyc;
    @(posedge ref_clk);
    capture <= 1'b0;
    rx_pkt();
    check_pkt(t0, t0 + 32'd16);
    rx_pkt();
    check_pkt(t, t + 32'd16);
  endtask : back_scn

  // Read-time frame from the companion; stamp taken after arrival
  task automatic api_scn;
    logic [31:0] t;
    @(posedge ref_clk);
    tx_data  <= 8'h17;
    tx_valid <= 1'b1;
    tx_last  <= 1'b1;
    t = cyc;
    for (int i = 0; i < 8000 && !tx_ready; i++)
      @(negedge ref_clk);
    check("taken", tx_ready, 1'b1);
    @(posedge ref_clk);
    tx_valid <= 1'b0;
    tx_last  <= 1'b0;
    rx_pkt();
    check_pkt(t + 32'd5000, cyc);
    check("api byte", api_rx_data, 8'h7e);
  endtask : api_scn

  // One byte round the command line, start bit timed
  task automatic cli_scn;
    int n;
    n = 0;
    check("cli ready", cli_tx_ready, 1'b1);
    @(posedge ref_clk);
    cli_tx_data  <= 8'ha5;
    cli_tx_valid <= 1'b1;
    @(posedge ref_clk);
    cli_tx_valid <= 1'b0;
    for (int i = 0; i < 200 && lk.cli_tx; i++)
      @(negedge ref_clk);
    while (!lk.cli_tx && n < 3000)
    begin
      n++;
      @(negedge ref_clk);
    end
    check("cli bit", 32'(n), 32'd2083);
    for (int i = 0; i < 25000 && !cli_rx_valid; i++)
      @(negedge ref_clk);
    check("cli done", cli_rx_valid, 1'b1);
    check("cli byte", cli_rx_data, 8'ha5);
  endtask : cli_scn

  initial
  begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (10) @(negedge ref_clk);
    check("idle awake", awake, 1'b0);
    strobe_scn();
    back_scn();
    api_scn();
    cli_scn();
    test_done();
  end
endmodule : api_uart_flow_time_capture_bench
